// ---- hw/wbl_pkg.sv ----
// Purpose: shared constants and types of the work bit logic unit
// Assumes: 125 MHz clock, Avalon-MM register access, byte addresses
// Notes: one configuration, source and delay word per work bit
package wbl_pkg;
   localparam int WBL_BITS = 8;
   localparam int WBL_SRC_W = 6;
   localparam int WBL_DLY_W = 14;
   localparam logic [13:0] WBL_DLY_MAX = 14'h270F;
   localparam int WBL_EVENTS = 6;
   localparam int WBL_SRC_CODES = 37;
   // Timebase
   localparam longint WBL_CLK_HZ = 125000000;
   localparam longint WBL_UNIT_S = 1;
   localparam longint WBL_SEC_CYCLES = WBL_UNIT_S * WBL_CLK_HZ;
   localparam int WBL_SEC_PER_MIN = 60;
   // Operation types
   localparam logic [2:0] WBL_OP_NONE = 3'h0;
   localparam logic [2:0] WBL_OP_AB_OR_CD = 3'h1;
   localparam logic [2:0] WBL_OP_AC_AND_BD = 3'h2;
   localparam logic [2:0] WBL_OP_ANY = 3'h3;
   localparam logic [2:0] WBL_OP_ALL = 3'h4;
   // Source codes
   localparam logic [5:0] WBL_SRC_OFF = 6'h00;
   localparam logic [5:0] WBL_SRC_ON = 6'h01;
   localparam logic [5:0] WBL_SRC_PWRUP = 6'h02;
   localparam logic [5:0] WBL_SRC_EVT1 = 6'h03;
   localparam logic [5:0] WBL_SRC_WB1 = 6'h1D;
   localparam logic [5:0] WBL_SRC_LAST = 6'h24;
   // Register map, byte addresses
   localparam logic [7:0] WBL_CFG_BASE = 8'h00;
   localparam logic [7:0] WBL_SRC_BASE = 8'h20;
   localparam logic [7:0] WBL_DLY_BASE = 8'h40;
   localparam logic [7:0] WBL_STATUS = 8'h60;
   // Configuration word fields
   localparam int WBL_CFG_OP_LSB = 0;
   localparam int WBL_CFG_OUT_NC = 4;
   localparam int WBL_CFG_IN_NC_LSB = 8;
   localparam int WBL_CFG_MINUTES = 12;
   // Source word fields, input A..D at 8 bit steps
   localparam int WBL_SRC_STEP = 8;
   // Delay word fields
   localparam int WBL_DLY_ON_LSB = 0;
   localparam int WBL_DLY_OFF_LSB = 16;
   // Status word fields
   localparam int WBL_ST_BITS_LSB = 0;
   localparam int WBL_ST_IN_USE = 8;
   localparam int WBL_ST_ADJ_LSB = 16;
   // Reset values
   localparam logic [31:0] WBL_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] WBL_SRC_RST = 32'h0000_0000;
   localparam logic [31:0] WBL_DLY_RST = 32'h0000_0000;

   typedef struct packed {
      logic [3:0] alarm;
      logic heat_out;
      logic cool_out;
      logic input_error;
      logic remote_setpoint_error;
      logic heater_burnout_alarm;
      logic heater_short_alarm;
      logic auto_manual;
      logic run_stop;
      logic remote_setpoint;
      logic program_start;
      logic autotune;
      logic setpoint_ramp;
      logic [2:0] multi_setpoint_select;
      logic program_end;
   } wbl_status_t;

   typedef struct packed {
      logic [2:0] op;
      logic out_nc;
      logic [3:0] in_nc;
      logic minutes;
   } wbl_cfg_t;
endpackage

// ---- hw/wbl_delay_timer.sv ----
// Purpose: ON/OFF delay and output flop of one work bit
// Assumes: eval and unit_tick are one-cycle pulses
// Notes: output changes only on an evaluation pulse, or clears on hold_off
`timescale 1ns/10ps
module wbl_delay_timer
   import wbl_pkg::*;
#(
   parameter int DW = WBL_DLY_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic eval,
   input wire logic unit_tick,
   input wire logic hold_off,
   input wire logic res,
   input wire logic [DW-1:0] on_dly,
   input wire logic [DW-1:0] off_dly,
   output logic work_bit
);
   typedef enum logic [2:0] {
      WBL_ST_IDLE = 3'b001,
      WBL_ST_WAIT_ON = 3'b010,
      WBL_ST_WAIT_OFF = 3'b100
   } wbl_tmr_state_t;

   wbl_tmr_state_t st;
   logic [DW-1:0] cnt;
   logic [DW-1:0] target;

   assign target = res ? on_dly : off_dly;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= WBL_ST_IDLE;
         cnt <= '0;
         work_bit <= 1'b0;
      end else if (ce) begin
         if (hold_off) begin
            st <= WBL_ST_IDLE;
            cnt <= '0;
            work_bit <= 1'b0;
         end else if (eval) begin
            if (res == work_bit) begin
               st <= WBL_ST_IDLE;
               cnt <= '0;
            end else if (cnt >= target) begin
               work_bit <= res;
               st <= WBL_ST_IDLE;
               cnt <= '0;
            end else begin
               st <= res ? WBL_ST_WAIT_ON : WBL_ST_WAIT_OFF;
               // Unit tick in an evaluation cycle counts unless the timer was idle
               if (unit_tick && st != WBL_ST_IDLE && cnt != {DW{1'b1}}) begin
                  cnt <= cnt + 1'b1;
               end
            end
         end else if (unit_tick) begin
            case (st)
               WBL_ST_WAIT_ON, WBL_ST_WAIT_OFF: begin
                  if (cnt != {DW{1'b1}}) begin
                     cnt <= cnt + 1'b1;
                  end
               end
               WBL_ST_IDLE: begin
                  cnt <= '0;
               end
               default: begin
                  st <= WBL_ST_IDLE;
               end
            endcase
         end
      end
   end

   a_hold_off_low: assert property (@(posedge clk) disable iff (!rst_n)
      ce && hold_off |=> !work_bit) else $error("work bit not held off");
   a_zero_on_dly: assert property (@(posedge clk) disable iff (!rst_n)
      ce && eval && !hold_off && res && !work_bit && on_dly == '0 |=> work_bit)
      else $error("zero ON delay not immediate");
   a_on_not_early: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(work_bit) |-> $past(cnt) >= $past(on_dly))
      else $error("work bit turned on before ON delay");
   a_off_not_early: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(work_bit) && !$past(hold_off) |-> $past(cnt) >= $past(off_dly))
      else $error("work bit turned off before OFF delay");
   a_cancel_idle: assert property (@(posedge clk) disable iff (!rst_n)
      ce && eval && !hold_off && res == work_bit |=> st == WBL_ST_IDLE && cnt == '0
      && $stable(work_bit)) else $error("pending delay not cancelled");
endmodule

// ---- hw/wbl_logic_unit.sv ----
// Purpose: eight configurable work bits with ON/OFF delays
// Assumes: cycle_tick marks one control cycle; Avalon-MM slave
// Notes: readdata and waitrequest are registered
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module wbl_logic_unit
   import wbl_pkg::*;
#(
   parameter int NBITS = WBL_BITS,
   parameter int EVENTS = WBL_EVENTS,
   parameter longint SEC_CYCLES = WBL_SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic cycle_tick,
   input wire logic [WBL_EVENTS-1:0] event_in,
   input wire wbl_status_t status,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [NBITS-1:0] work_bit,
   output logic logic_in_use,
   output logic [NBITS-1:0] delay_adjustable
);
   wbl_cfg_t cfg [NBITS];
   logic [WBL_SRC_W-1:0] src_sel [NBITS][4];
   logic [WBL_DLY_W-1:0] on_dly [NBITS];
   logic [WBL_DLY_W-1:0] off_dly [NBITS];
   logic [WBL_SRC_CODES-1:0] src_vec;
   logic [NBITS-1:0] comb_res;
   logic [NBITS-1:0] op_none;
   logic [NBITS-1:0] unit_tick;
   logic power_pulse;
   logic [31:0] sec_cnt;
   logic [5:0] min_cnt;
   logic sec_tick;
   logic min_tick;
   logic [31:0] wmask;
   logic [2:0] widx;
   logic acc;
   logic [31:0] next_readdata;

   // One-cycle pulse after power-up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_pulse <= 1'b1;
      end else if (ce && cycle_tick) begin
         power_pulse <= 1'b0;
      end
   end

   // Second and minute ticks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_cnt <= '0;
         min_cnt <= '0;
         sec_tick <= 1'b0;
         min_tick <= 1'b0;
      end else if (ce) begin
         sec_tick <= 1'b0;
         min_tick <= 1'b0;
         if (sec_cnt >= 32'(SEC_CYCLES - 1)) begin
            sec_cnt <= '0;
            sec_tick <= 1'b1;
            if (min_cnt >= 6'(WBL_SEC_PER_MIN - 1)) begin
               min_cnt <= '0;
               min_tick <= 1'b1;
            end else begin
               min_cnt <= min_cnt + 6'h01;
            end
         end else begin
            sec_cnt <= sec_cnt + 32'h0000_0001;
         end
      end
   end

   // Source vector indexed by source code
   always_comb begin
      src_vec = '0;
      src_vec[WBL_SRC_OFF] = 1'b0;
      src_vec[WBL_SRC_ON] = 1'b1;
      src_vec[WBL_SRC_PWRUP] = power_pulse;
      for (int e = 0; e < WBL_EVENTS; e++) begin
         src_vec[int'(WBL_SRC_EVT1) + e] = (e < EVENTS) ? event_in[e] : 1'b0;
      end
      src_vec[12:9] = status.alarm;
      src_vec[13] = status.heat_out;
      src_vec[14] = status.cool_out;
      src_vec[15] = status.input_error;
      src_vec[16] = status.remote_setpoint_error;
      src_vec[17] = status.heater_burnout_alarm;
      src_vec[18] = status.heater_short_alarm;
      src_vec[19] = status.auto_manual;
      src_vec[20] = status.run_stop;
      src_vec[21] = status.remote_setpoint;
      src_vec[22] = status.program_start;
      src_vec[23] = status.autotune;
      src_vec[24] = status.setpoint_ramp;
      src_vec[27:25] = status.multi_setpoint_select;
      src_vec[28] = status.program_end;
      for (int w = 0; w < WBL_BITS; w++) begin
         src_vec[int'(WBL_SRC_WB1) + w] = (w < NBITS) ? work_bit[w] : 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NBITS; g++) begin : gen_bit
         logic [3:0] cond;
         logic raw;
         always_comb begin
            for (int k = 0; k < 4; k++) begin
               cond[k] = (src_sel[g][k] <= WBL_SRC_LAST) ?
                  src_vec[src_sel[g][k]] ^ cfg[g].in_nc[k] : cfg[g].in_nc[k];
            end
            case (cfg[g].op)
               WBL_OP_AB_OR_CD: raw = (cond[0] & cond[1]) | (cond[2] & cond[3]);
               WBL_OP_AC_AND_BD: raw = (cond[0] | cond[2]) & (cond[1] | cond[3]);
               WBL_OP_ANY: raw = |cond;
               WBL_OP_ALL: raw = &cond;
               default: raw = 1'b0;
            endcase
         end
         assign op_none[g] = (cfg[g].op == WBL_OP_NONE);
         assign comb_res[g] = raw ^ cfg[g].out_nc;
         assign unit_tick[g] = cfg[g].minutes ? min_tick : sec_tick;

         wbl_delay_timer #(
            .DW(WBL_DLY_W)
         ) u_tmr (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .eval(cycle_tick),
            .unit_tick(unit_tick[g]),
            .hold_off(op_none[g]),
            .res(comb_res[g]),
            .on_dly(on_dly[g]),
            .off_dly(off_dly[g]),
            .work_bit(work_bit[g])
         );

         a_op_or: assert property (@(posedge clk) disable iff (!rst_n)
            cfg[g].op == WBL_OP_ANY |-> comb_res[g] == ((|cond) ^ cfg[g].out_nc))
            else $error("OR form wrong");
         a_op_and: assert property (@(posedge clk) disable iff (!rst_n)
            cfg[g].op == WBL_OP_ALL && !cfg[g].out_nc |-> comb_res[g] == (&cond))
            else $error("AND form wrong");
         a_op_sum: assert property (@(posedge clk) disable iff (!rst_n)
            cfg[g].op == WBL_OP_AB_OR_CD && !cfg[g].out_nc && cond == 4'h3 |-> comb_res[g])
            else $error("type 1 form wrong");
         a_op_prod: assert property (@(posedge clk) disable iff (!rst_n)
            cfg[g].op == WBL_OP_AC_AND_BD && !cfg[g].out_nc && cond == 4'h3 |-> comb_res[g])
            else $error("type 2 form wrong");
      end
   endgenerate

   // Indicators
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         logic_in_use <= 1'b0;
         delay_adjustable <= '0;
      end else if (ce) begin
         logic_in_use <= ~&op_none;
         delay_adjustable <= ~op_none;
      end
   end

   // Bus decode
   assign widx = address[4:2];
   assign acc = (read || write) && waitrequest;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[8*b +: 8] = {8{byteenable[b]}};
      end
   end

   // Configuration writes, taken when waitrequest is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NBITS; i++) begin
            cfg[i] <= WBL_CFG_RST[8:0];
            for (int k = 0; k < 4; k++) begin
               src_sel[i][k] <= WBL_SRC_RST[5:0];
            end
            on_dly[i] <= WBL_DLY_RST[13:0];
            off_dly[i] <= WBL_DLY_RST[29:16];
         end
      end else if (ce && write && !waitrequest && 32'(widx) < NBITS) begin
         logic [31:0] cur;
         logic [31:0] nw;
         cur = '0;
         nw = '0;
         case (address & 8'hE3)
            WBL_CFG_BASE: begin
               cur = {19'h0, cfg[widx].minutes, cfg[widx].in_nc, 3'h0,
                  cfg[widx].out_nc, 1'b0, cfg[widx].op};
               nw = (cur & ~wmask) | (writedata & wmask);
               cfg[widx].op <= nw[WBL_CFG_OP_LSB +: 3];
               cfg[widx].out_nc <= nw[WBL_CFG_OUT_NC];
               cfg[widx].in_nc <= nw[WBL_CFG_IN_NC_LSB +: 4];
               cfg[widx].minutes <= nw[WBL_CFG_MINUTES];
            end
            WBL_SRC_BASE: begin
               for (int k = 0; k < 4; k++) begin
                  if (byteenable[k]) begin
                     src_sel[widx][k] <= writedata[WBL_SRC_STEP*k +: WBL_SRC_W];
                  end
               end
            end
            WBL_DLY_BASE: begin
               if (!op_none[widx]) begin
                  cur = {2'h0, off_dly[widx], 2'h0, on_dly[widx]};
                  nw = (cur & ~wmask) | (writedata & wmask);
                  on_dly[widx] <= (nw[13:0] > WBL_DLY_MAX) ? WBL_DLY_MAX : nw[13:0];
                  off_dly[widx] <= (nw[29:16] > WBL_DLY_MAX) ? WBL_DLY_MAX : nw[29:16];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux
   always_comb begin
      next_readdata = 32'h0000_0000;
      if (address == WBL_STATUS) begin
         next_readdata[WBL_ST_BITS_LSB +: WBL_BITS] = 8'(work_bit);
         next_readdata[WBL_ST_IN_USE] = logic_in_use;
         next_readdata[WBL_ST_ADJ_LSB +: WBL_BITS] = 8'(delay_adjustable);
      end else if (32'(widx) < NBITS) begin
         case (address & 8'hE3)
            WBL_CFG_BASE: next_readdata = {19'h0, cfg[widx].minutes, cfg[widx].in_nc,
               3'h0, cfg[widx].out_nc, 1'b0, cfg[widx].op};
            WBL_SRC_BASE: next_readdata = {2'h0, src_sel[widx][3], 2'h0, src_sel[widx][2],
               2'h0, src_sel[widx][1], 2'h0, src_sel[widx][0]};
            WBL_DLY_BASE: next_readdata = {2'h0, off_dly[widx], 2'h0, on_dly[widx]};
            default: next_readdata = 32'h0000_0000;
         endcase
      end
   end

   // One wait state per access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
         readdata <= 32'h0000_0000;
      end else if (ce) begin
         if (acc) begin
            waitrequest <= 1'b0;
            if (read) begin
               readdata <= next_readdata;
            end
         end else begin
            waitrequest <= 1'b1;
         end
      end
   end

   a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
      ce && acc |=> !waitrequest) else $error("bus access not answered");
   a_in_use_flag: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !(&op_none) |=> logic_in_use) else $error("in-use indicator missing");
   a_pwr_pulse_once: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cycle_tick |=> !power_pulse [*2]) else $error("power-up pulse repeated");
   a_delay_locked: assert property (@(posedge clk) disable iff (!rst_n)
      op_none[0] |=> $stable(on_dly[0]) && $stable(off_dly[0]))
      else $error("delay changed with no operation");
endmodule

// ---- bench/wbl_ctrl_model.sv ----
// Purpose: controller side model feeding status, events and ticks
// Assumes: one source code is raised at a time
// Notes: control cycle tick every TICK_GAP clocks while tick_en
`timescale 1ns/10ps
module wbl_ctrl_model
   import wbl_pkg::*;
#(
   parameter int TICK_GAP = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick_en,
   input wire logic [5:0] src_code,
   input wire logic level,
   output logic cycle_tick,
   output logic [WBL_EVENTS-1:0] event_in,
   output wbl_status_t status
);
   localparam int SW = $bits(wbl_status_t);
   int cnt;
   // Control cycle strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         cycle_tick <= 1'b0;
      end else begin
         cnt <= (cnt == TICK_GAP - 1) ? 0 : cnt + 1;
         cycle_tick <= tick_en && (cnt == 0);
      end
   end
   // Source code to one event or status line
   always @(posedge clk) begin
      event_in <= '0;
      status <= '0;
      if (level && src_code >= 6'h03 && src_code <= 6'h08)
         event_in[src_code - 6'h03] <= 1'b1;
      else if (level && src_code >= 6'h09 && src_code <= 6'h0C)
         status.alarm[src_code - 6'h09] <= 1'b1;
      else if (level && src_code >= 6'h0D && src_code <= 6'h18)
         status[SW + 8 - int'(src_code)] <= 1'b1;
      else if (level && src_code >= 6'h19 && src_code <= 6'h1B)
         status.multi_setpoint_select[src_code - 6'h19] <= 1'b1;
      else if (level && src_code == 6'h1C)
         status.program_end <= 1'b1;
   end
endmodule

// ---- bench/tb_wbl_logic_unit.sv ----
// Purpose: self-checking bench of the work bit logic unit
// Assumes: SEC_CYCLES of 10, tick every 4 clocks
// Notes: ce held high
`timescale 1ns/10ps
module tb_wbl_logic_unit
   import wbl_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic tick_en = 1'b0;
   logic [5:0] src_code = 6'h00;
   logic level = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitrequest;
   logic [7:0] work_bit;
   logic logic_in_use;
   logic [7:0] delay_adjustable;
   logic cycle_tick;
   logic [5:0] event_in;
   wbl_status_t status;
   int err_count = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   wbl_ctrl_model ctrl (.clk(clk), .rst_n(rst_n), .tick_en(tick_en), .src_code(src_code),
      .level(level), .cycle_tick(cycle_tick), .event_in(event_in), .status(status));
   wbl_logic_unit #(.SEC_CYCLES(10)) uut (.clk(clk), .rst_n(rst_n), .ce(ce),
      .cycle_tick(cycle_tick), .event_in(event_in), .status(status), .address(address),
      .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .work_bit(work_bit),
      .logic_in_use(logic_in_use), .delay_adjustable(delay_adjustable));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(q, exp);
   endtask
   task automatic wait_ticks(input int n);
      repeat (n) do @(posedge clk); while (cycle_tick !== 1'b1);
      #1;
   endtask
   task automatic measure(input int i, input logic lv, input int lim, output int n);
      n = 0;
      while (work_bit[i] !== lv && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   function automatic logic [31:0] cfgw(input logic [2:0] op, input logic onc,
                                        input logic [3:0] innc, input logic mins);
      return {19'h0, mins, innc, 3'h0, onc, 1'b0, op};
   endfunction
   function automatic logic [31:0] srcw(input logic [5:0] a, b, c, d);
      return {2'b0, d, 2'b0, c, 2'b0, b, 2'b0, a};
   endfunction
   function automatic logic comb(input int op, input logic [3:0] v);
      case (op)
         1: return (v[0] & v[1]) | (v[2] & v[3]);
         2: return (v[0] | v[2]) & (v[1] | v[3]);
         3: return |v;
         default: return &v;
      endcase
   endfunction
   function automatic logic [7:0] adr(input logic [7:0] base, input int i);
      return base + 8'(i * 4);
   endfunction

   task automatic t_reset();
      check(work_bit, 8'h00);
      check({logic_in_use, delay_adjustable}, 9'h000);
      rd_chk(WBL_CFG_BASE, WBL_CFG_RST);
      rd_chk(WBL_SRC_BASE, WBL_SRC_RST);
      rd_chk(WBL_DLY_BASE, WBL_DLY_RST);
      rd_chk(8'h80, 32'h0000_0000);
   endtask
   task automatic t_powerup();
      wr(adr(WBL_CFG_BASE, 0), cfgw(3'h3, 1'b0, 4'h0, 1'b0));
      wr(adr(WBL_SRC_BASE, 0), srcw(WBL_SRC_PWRUP, 6'h00, 6'h00, 6'h00));
      wr(adr(WBL_CFG_BASE, 1), cfgw(3'h3, 1'b0, 4'h0, 1'b0));
      wr(adr(WBL_SRC_BASE, 1), srcw(WBL_SRC_ON, 6'h00, 6'h00, 6'h00));
      wr(adr(WBL_CFG_BASE, 2), cfgw(3'h3, 1'b0, 4'h0, 1'b0));
      wr(adr(WBL_SRC_BASE, 2), srcw(WBL_SRC_WB1, 6'h00, 6'h00, 6'h00));
      tick_en <= 1'b1;
      wait_ticks(1);
      check(work_bit[2:0], 3'b011);
      wait_ticks(1);
      check(work_bit[2:0], 3'b110);
      wait_ticks(1);
      check(work_bit[2:0], 3'b010);
   endtask
   task automatic t_ops();
      logic [3:0] nc;
      logic [3:0] s;
      for (int op = 1; op <= 4; op++) begin
         for (int p = 0; p < 2; p++) begin
            nc = p ? 4'hF : 4'h0;
            for (int c = 0; c < 16; c++) begin
               s = 4'(c) ^ nc;
               wr(adr(WBL_CFG_BASE, 3), cfgw(3'(op), p[0], nc, 1'b0));
               wr(adr(WBL_SRC_BASE, 3), srcw({5'h0, s[0]}, {5'h0, s[1]}, {5'h0, s[2]},
                  {5'h0, s[3]}));
               wait_ticks(2);
               check(work_bit[3], comb(op, 4'(c)) ^ p[0]);
            end
         end
      end
      wr(adr(WBL_CFG_BASE, 3), cfgw(3'h3, 1'b0, 4'h0, 1'b0));
      wr(adr(WBL_SRC_BASE, 3), srcw(6'h3F, 6'h25, 6'h00, 6'h00));
      wait_ticks(2);
      check(work_bit[3], 1'b0);
      wr(adr(WBL_CFG_BASE, 3), cfgw(3'h5, 1'b0, 4'h0, 1'b0));
      wr(adr(WBL_SRC_BASE, 3), srcw(WBL_SRC_ON, WBL_SRC_ON, WBL_SRC_ON, WBL_SRC_ON));
      wait_ticks(2);
      check(work_bit[3], 1'b0);
   endtask
   task automatic t_sources();
      wr(adr(WBL_CFG_BASE, 4), cfgw(3'h3, 1'b0, 4'h0, 1'b0));
      for (int c = 3; c <= 28; c++) begin
         src_code <= 6'(c);
         wr(adr(WBL_SRC_BASE, 4), srcw(6'h00, 6'h00, 6'(c), 6'h00));
         level <= 1'b1;
         wait_ticks(2);
         check(work_bit[4], 1'b1);
         level <= 1'b0;
         wait_ticks(2);
         check(work_bit[4], 1'b0);
      end
   endtask
   task automatic t_delays();
      int n;
      wr(adr(WBL_DLY_BASE, 5), 32'h0002_0003);
      rd_chk(adr(WBL_DLY_BASE, 5), 32'h0000_0000);
      check(delay_adjustable[5], 1'b0);
      wr(adr(WBL_CFG_BASE, 5), cfgw(3'h3, 1'b0, 4'h0, 1'b0));
      wr(adr(WBL_SRC_BASE, 5), srcw(WBL_SRC_EVT1, 6'h00, 6'h00, 6'h00));
      wr(adr(WBL_DLY_BASE, 5), 32'h0002_3FFF);
      rd_chk(adr(WBL_DLY_BASE, 5), {16'h0002, 2'b00, WBL_DLY_MAX});
      check(delay_adjustable[5], 1'b1);
      check(logic_in_use, 1'b1);
      wr(adr(WBL_DLY_BASE, 5), 32'h0002_0003);
      src_code <= WBL_SRC_EVT1;
      @(posedge clk);
      level <= 1'b1;
      measure(5, 1'b1, 200, n);
      check(n >= 20 && n <= 42, 1'b1);
      @(posedge clk);
      level <= 1'b0;
      repeat (6) @(posedge clk);
      level <= 1'b1;
      measure(5, 1'b0, 60, n);
      check(n, 60);
      @(posedge clk);
      level <= 1'b0;
      measure(5, 1'b0, 200, n);
      check(n >= 10 && n <= 32, 1'b1);
      wr(adr(WBL_CFG_BASE, 5), cfgw(3'h3, 1'b0, 4'h0, 1'b1));
      wr(adr(WBL_DLY_BASE, 5), 32'h0000_0002);
      level <= 1'b1;
      measure(5, 1'b1, 2000, n);
      check(n >= 600 && n <= 1300, 1'b1);
      level <= 1'b0;
      measure(5, 1'b0, 100, n);
      check(n <= 14, 1'b1);
   endtask
   task automatic t_clear();
      wr(WBL_STATUS, 32'hFFFF_FFFF);
      for (int i = 0; i < 8; i++)
         wr(adr(WBL_CFG_BASE, i), cfgw(3'h0, 1'b1, 4'hF, 1'b0));
      wait_ticks(2);
      check(work_bit, 8'h00);
      check({logic_in_use, delay_adjustable}, 9'h000);
      rd_chk(WBL_STATUS, 32'h0000_0000);
   endtask
   task automatic complete_run();
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      #400000;
      err_count++;
      complete_run();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_powerup();
      t_ops();
      t_sources();
      t_delays();
      t_clear();
      complete_run();
   end
endmodule
